/* hw/smf_pkg.sv */
package smf_pkg;

	// Pin routing selector codes
	localparam logic [3:0] FAULT_SEL_SERIAL = 4'h1;
	localparam logic [3:0] TDATA_SEL_SERIAL = 4'h4;

	// Field widths of the control word
	localparam int TX_CNT_W  = 4;
	localparam int RX_CNT_W  = 5;
	localparam int FRM_CNT_W = 5;

	// Buffer geometry
	localparam int TX_BYTES = 8;
	localparam int RX_BYTES = 16;
	localparam int RX_IDX_W = 4;
	localparam int TX_IDX_W = 3;

	// Reset values
	localparam logic CS_DIR_RESET  = 1'b1;
	localparam logic CS_IDLE_LEVEL = 1'b1;

	// Serial clock half period
	localparam int CLK_PERIOD_PS  = 5000;
	localparam int SCLK_HALF_NS   = 100;
	localparam int SCLK_HALF_CYC  = (SCLK_HALF_NS * 1000) / CLK_PERIOD_PS;

	typedef enum logic [1:0] {
		SMF_IDLE,
		SMF_XFER
	} smf_fsm_t;

endpackage

/* hw/smf_tick_div.sv */
`timescale 1ns/1ps
// Free running divider giving one-cycle enable pulses while run is high
module smf_tick_div
	import smf_pkg::*;
#(
	parameter int HALF_CYC = SCLK_HALF_CYC
) (
	// Clock and reset
	input  wire logic i_clock,
	input  wire logic i_arst_n,
	// Control
	input  wire logic i_run,
	// Enable out
	output logic      o_tick
);

	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} smf_div_t;

	smf_div_t s_ff;
	smf_div_t nxt_s;

	// Count down, restart on every pulse or when idle
	always_comb begin
		nxt_s      = s_ff;
		nxt_s.tick = 1'b0;
		if (!i_run) begin
			nxt_s.cnt = 16'(HALF_CYC - 1);
		end else if (s_ff.cnt == 16'h0000) begin
			nxt_s.cnt  = 16'(HALF_CYC - 1);
			nxt_s.tick = 1'b1;
		end else begin
			nxt_s.cnt = s_ff.cnt - 16'h0001;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign o_tick = s_ff.tick;

endmodule // smf_tick_div

/* hw/smf_rx_mem.sv */
`timescale 1ns/1ps
// Receive buffer: byte writes, registered word reads
module smf_rx_mem
	import smf_pkg::*;
(
	// Clock and reset
	input  wire logic                i_clock,
	input  wire logic                i_arst_n,
	// Byte write port
	input  wire logic                i_wr,
	input  wire logic [RX_IDX_W-1:0] i_wr_idx,
	input  wire logic [7:0]          i_wr_byte,
	// Word read port
	input  wire logic [1:0]          i_rd_word,
	output logic      [31:0]         o_rd_data
);

	typedef struct packed {
		logic [RX_BYTES-1:0][7:0] mem;
		logic [31:0]              rd;
	} smf_mem_t;

	smf_mem_t s_ff;
	smf_mem_t nxt_s;

	// First byte lands in the low byte of word zero
	always_comb begin
		nxt_s = s_ff;
		if (i_wr) begin
			nxt_s.mem[i_wr_idx] = i_wr_byte;
		end
		nxt_s.rd = {s_ff.mem[{i_rd_word, 2'b11}], s_ff.mem[{i_rd_word, 2'b10}],
			s_ff.mem[{i_rd_word, 2'b01}], s_ff.mem[{i_rd_word, 2'b00}]};
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign o_rd_data = s_ff.rd;

endmodule // smf_rx_mem

/* hw/smf_engine.sv */
`timescale 1ns/1ps
module smf_engine
	import smf_pkg::*;
#(
	parameter int HALF_CYC = SCLK_HALF_CYC
) (
	// Clock and reset
	input  wire logic                 i_clock,
	input  wire logic                 i_arst_n,
	// Control bits
	input  wire logic                 i_serial_enable_bit,
	input  wire logic [TX_CNT_W-1:0]  i_transmit_count,
	input  wire logic [RX_CNT_W-1:0]  i_receive_count,
	input  wire logic [FRM_CNT_W-1:0] i_frame_message_count,
	input  wire logic                 i_start_register_select,
	// Transmit word writes
	input  wire logic                 i_tx_first_wr,
	input  wire logic                 i_tx_second_wr,
	input  wire logic [31:0]          i_tx_wdata,
	// Status
	input  wire logic                 i_done_clear,
	output logic                      o_done_flag,
	output logic                      o_busy,
	// Receive word read
	input  wire logic [1:0]           i_rx_word_sel,
	output logic      [31:0]          o_rx_word,
	// Chip select pin function and direction
	input  wire logic                 i_chip_select_field_func,
	input  wire logic                 i_cs_dir_wr,
	input  wire logic                 i_cs_dir_val,
	input  wire logic                 i_cs_gp_out,
	output logic                      o_cs_dir,
	// Pin routing
	input  wire logic [3:0]           i_fault_mux_sel,
	input  wire logic [3:0]           i_tdata_mux_sel,
	// Pins
	output logic                      o_fault_pin_zero,
	output logic                      o_fault_pin_zero_oe,
	output logic                      o_fault_pin_one,
	output logic                      o_fault_pin_one_oe,
	output logic                      o_serial_out_pin,
	output logic                      o_serial_out_pin_oe,
	input  wire logic                 i_serial_in_pin,
	output logic                      o_cs_gp_in
);

	// Engine state apart from the divider and receive buffer, registered in one place
	typedef struct packed {
		smf_fsm_t               fsm;
		logic [31:0]            tx0;
		logic [31:0]            tx1;
		logic [TX_CNT_W-1:0]    tx_left;
		logic [RX_CNT_W-1:0]    rx_left;
		logic [TX_IDX_W-1:0]    tx_idx;
		logic [RX_IDX_W-1:0]    rx_idx;
		logic [2:0]             bit_cnt;
		logic [7:0]             sh;
		logic                   rx_phase;
		logic                   sclk;
		logic                   cs_act;
		logic [FRM_CNT_W-1:0]   msg_left;
		logic                   done;
		logic                   busy;
		logic                   cs_dir;
		logic                   in_meta;
		logic                   in_sync;
		logic                   cs_meta;
		logic                   cs_sync;
		logic                   pin_cs;
		logic                   pin_cs_oe;
		logic                   pin_clk;
		logic                   pin_clk_oe;
		logic                   pin_out;
		logic                   pin_out_oe;
	} smf_state_t;

	smf_state_t s_ff;
	smf_state_t nxt_s;
	// Divider pulse and receive buffer byte strobe
	logic       tick;
	logic       rx_wr;

	// Byte of the transmit buffer, low byte of each word first
	// The index wraps after eight, so counts above eight start over at word zero
	function automatic logic [7:0] tx_byte(input logic [31:0] w0, input logic [31:0] w1,
		input logic [TX_IDX_W-1:0] idx);
		logic [31:0] w;
		w = idx[2] ? w1 : w0;
		return w[{idx[1:0], 3'b000} +: 8];
	endfunction

	// Last bit of a byte, shared by the shifter and the buffer write
	function automatic logic byte_end(input logic [2:0] cnt);
		return cnt == 3'h7;
	endfunction

	// Serial routing decode, shared by the select and clock pins
	function automatic logic fault_route_on(input logic [3:0] sel);
		return sel == FAULT_SEL_SERIAL;
	endfunction

	// Half-period pulses; the divider reloads outside messages, so the
	// first rising edge comes a half period plus one clock after select falls
	smf_tick_div #(
		.HALF_CYC (HALF_CYC)
	) u_div (
		.i_clock  (i_clock),
		.i_arst_n (i_arst_n),
		.i_run    (s_ff.fsm == SMF_XFER),
		.o_tick   (tick)
	);

	// Receive buffer; wraps after sixteen bytes, so long reads overwrite
	smf_rx_mem u_rx (
		.i_clock   (i_clock),
		.i_arst_n  (i_arst_n),
		.i_wr      (rx_wr),
		.i_wr_idx  (s_ff.rx_idx),
		.i_wr_byte (s_ff.sh),
		.i_rd_word (i_rx_word_sel),
		.o_rd_data (o_rx_word)
	);

	// Receive byte completes on the falling edge of its last bit; the shift
	// register already holds all eight bits at that edge
	assign rx_wr = (s_ff.fsm == SMF_XFER) && tick && s_ff.sclk && s_ff.rx_phase
		&& byte_end(s_ff.bit_cnt);

	// Message sequencing, frame tracking and pin routing
	always_comb begin
		logic start;
		logic fin;
		start   = 1'b0;
		fin     = 1'b0;
		nxt_s   = s_ff;

		// Serial input synchroniser; its two-cycle lag bounds the shortest
		// usable half period, since data must settle before the rising edge
		nxt_s.in_meta = i_serial_in_pin;
		nxt_s.in_sync = s_ff.in_meta;
		// Select pin readback, delayed like a pin input
		nxt_s.cs_meta = s_ff.pin_cs;
		nxt_s.cs_sync = s_ff.cs_meta;

		// Transmit words are plain storage
		// Writes while busy still land and change the bytes not yet sent
		if (i_tx_first_wr) begin
			nxt_s.tx0 = i_tx_wdata;
		end
		if (i_tx_second_wr) begin
			nxt_s.tx1 = i_tx_wdata;
		end
		if (i_cs_dir_wr) begin
			nxt_s.cs_dir = i_cs_dir_val;
		end

		unique case (s_ff.fsm)
			SMF_IDLE: begin
				// Only the selected word's write launches; the other only stores
				start = i_serial_enable_bit && (i_start_register_select ?
					i_tx_second_wr : i_tx_first_wr);
			end
			SMF_XFER: begin
				// Rising edge samples into the shifter, falling edge counts bits and shifts transmit data
				if (tick && !s_ff.sclk) begin
					nxt_s.sclk = 1'b1;
					if (s_ff.rx_phase) begin
						nxt_s.sh = {s_ff.sh[6:0], s_ff.in_sync};
					end
				end else if (tick) begin
					nxt_s.sclk    = 1'b0;
					nxt_s.bit_cnt = s_ff.bit_cnt + 3'h1;
					if (!s_ff.rx_phase) begin
						nxt_s.sh = {s_ff.sh[6:0], 1'b0};
					end
					if (byte_end(s_ff.bit_cnt)) begin
						if (s_ff.rx_phase) begin
							nxt_s.rx_left = s_ff.rx_left - 5'h01;
							nxt_s.rx_idx  = s_ff.rx_idx + 4'h1;
						end else begin
							nxt_s.tx_left = s_ff.tx_left - 4'h1;
							nxt_s.tx_idx  = s_ff.tx_idx + 3'h1;
						end
						// Pick the next byte: transmit first, then receive
						if (nxt_s.tx_left != '0) begin
							nxt_s.sh = tx_byte(s_ff.tx0, s_ff.tx1, nxt_s.tx_idx);
						end else if (nxt_s.rx_left != '0) begin
							nxt_s.rx_phase = 1'b1;
							nxt_s.sh       = 8'h00;
						end else begin
							fin = 1'b1;
						end
					end
				end
			end
		endcase

		// Launch: counts are latched here only, so software may rewrite them
		// as soon as the done flag is seen, ahead of the next start
		if (start) begin
			nxt_s.tx_left  = i_transmit_count;
			nxt_s.rx_left  = i_receive_count;
			nxt_s.tx_idx   = '0;
			nxt_s.rx_idx   = '0;
			nxt_s.bit_cnt  = 3'h0;
			nxt_s.sclk     = 1'b0;
			nxt_s.cs_act   = 1'b1;
			nxt_s.rx_phase = (i_transmit_count == '0);
			nxt_s.sh       = (i_transmit_count == '0) ? 8'h00 :
				tx_byte(nxt_s.tx0, nxt_s.tx1, '0);
			// The frame count is taken only by the first message of a frame
			if (s_ff.msg_left == '0) begin
				nxt_s.msg_left = (i_frame_message_count == '0) ? 5'h01 :
					i_frame_message_count;
			end
			if (i_transmit_count == '0 && i_receive_count == '0) begin
				fin = 1'b1;
			end else begin
				nxt_s.fsm = SMF_XFER;
			end
		end

		// End of message: flag, frame count, select release
		// Select stays low between messages until the frame count runs out
		if (fin) begin
			nxt_s.fsm      = SMF_IDLE;
			nxt_s.sclk     = 1'b0;
			nxt_s.msg_left = nxt_s.msg_left - 5'h01;
			if (nxt_s.msg_left == '0) begin
				nxt_s.cs_act = 1'b0;
			end
		end
		nxt_s.done = (s_ff.done && !i_done_clear) || fin;

		// Disable aborts everything and frees the select line
		// An aborted message leaves the done flag as it was
		if (!i_serial_enable_bit) begin
			nxt_s.fsm      = SMF_IDLE;
			nxt_s.sclk     = 1'b0;
			nxt_s.cs_act   = 1'b0;
			nxt_s.msg_left = '0;
		end

		// Busy as a flop of its own, so the status output needs no decode
		nxt_s.busy = (nxt_s.fsm == SMF_XFER);

		// Registered pin routing
		nxt_s.pin_cs     = i_chip_select_field_func ? i_cs_gp_out :
			(nxt_s.cs_act ? ~CS_IDLE_LEVEL : CS_IDLE_LEVEL);
		nxt_s.pin_cs_oe  = fault_route_on(i_fault_mux_sel) &&
			(!i_chip_select_field_func || nxt_s.cs_dir);
		nxt_s.pin_clk    = nxt_s.sclk;
		nxt_s.pin_clk_oe = fault_route_on(i_fault_mux_sel);
		nxt_s.pin_out    = nxt_s.rx_phase ? 1'b0 : nxt_s.sh[7];
		nxt_s.pin_out_oe = (i_tdata_mux_sel == TDATA_SEL_SERIAL);
	end

	// State register; reset parks the select pin at its idle level and
	// the direction bit at output
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_ff        <= '0;
			s_ff.fsm    <= SMF_IDLE;
			s_ff.cs_dir <= CS_DIR_RESET;
			s_ff.pin_cs <= CS_IDLE_LEVEL;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs straight from state
	assign o_done_flag         = s_ff.done;
	assign o_busy              = s_ff.busy;
	assign o_cs_dir            = s_ff.cs_dir;
	assign o_cs_gp_in          = s_ff.cs_sync;
	assign o_fault_pin_zero    = s_ff.pin_cs;
	assign o_fault_pin_zero_oe = s_ff.pin_cs_oe;
	assign o_fault_pin_one     = s_ff.pin_clk;
	assign o_fault_pin_one_oe  = s_ff.pin_clk_oe;
	assign o_serial_out_pin    = s_ff.pin_out;
	assign o_serial_out_pin_oe = s_ff.pin_out_oe;

endmodule // smf_engine

/* test/smf_engine_assertions.sv */
`timescale 1ns/1ps
// Port-level checks of the frame engine
module smf_chk
	import smf_pkg::*;
(
	input wire logic i_clock, i_arst_n, i_serial_enable_bit, i_start_register_select,
	input wire logic i_tx_first_wr, i_tx_second_wr, i_done_clear, o_done_flag, o_busy,
	input wire logic i_chip_select_field_func, i_cs_gp_out, o_fault_pin_zero, o_fault_pin_one,
	input wire logic o_fault_pin_one_oe, o_serial_out_pin_oe,
	input wire logic [3:0] i_transmit_count, i_fault_mux_sel, i_tdata_mux_sel
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	// Idle, enabled engine with bytes to send
	sequence s_go;
		i_serial_enable_bit && !o_busy && !i_chip_select_field_func && i_transmit_count != 4'h0;
	endsequence
	a_start_first:
	assert property (s_go ##0 (i_tx_first_wr && !i_start_register_select) |=> o_busy
		&& !o_fault_pin_zero) else $error("no start");
	a_start_second:
	assert property (s_go ##0 (i_tx_second_wr && i_start_register_select) |=> o_busy)
		else $error("no start on second word");
	a_wrong_word:
	assert property (i_tx_first_wr && !i_tx_second_wr && i_start_register_select && !o_busy
		|=> !o_busy) else $error("start on stored word");
	a_stay_off:
	assert property (!i_serial_enable_bit && !o_busy |=> !o_busy) else $error("busy when off");
	a_done_hold:
	assert property (o_done_flag && !i_done_clear |=> o_done_flag) else $error("done lost");
	a_done_clear:
	assert property (i_done_clear && !o_busy && !i_tx_first_wr && !i_tx_second_wr
		|=> !o_done_flag) else $error("done kept");
	a_done_end:
	assert property (i_serial_enable_bit && $fell(o_busy) |-> o_done_flag) else $error("no done");
	a_sel_low:
	assert property (o_busy && !i_chip_select_field_func |-> !o_fault_pin_zero)
		else $error("select high");
	a_clk_idle:
	assert property (!o_busy |-> !o_fault_pin_one) else $error("clock moves");
	a_gp_pin:
	assert property (i_chip_select_field_func |=> o_fault_pin_zero == $past(i_cs_gp_out))
		else $error("gp select");
	a_route:
	assert property (1 |=> o_fault_pin_one_oe == ($past(i_fault_mux_sel) == FAULT_SEL_SERIAL)
		&& o_serial_out_pin_oe == ($past(i_tdata_mux_sel) == TDATA_SEL_SERIAL))
		else $error("routing");
endmodule // smf_chk

bind smf_engine smf_chk u_chk (.i_clock, .i_arst_n, .i_serial_enable_bit, .i_start_register_select,
	.i_tx_first_wr, .i_tx_second_wr, .i_done_clear, .o_done_flag, .o_busy,
	.i_chip_select_field_func, .i_cs_gp_out, .o_fault_pin_zero, .o_fault_pin_one,
	.o_fault_pin_one_oe, .o_serial_out_pin_oe, .i_transmit_count, .i_fault_mux_sel,
	.i_tdata_mux_sel);

/* test/smf_mem_model.sv */
`timescale 1ns/1ps
// Serial memory: takes data on rising clock, answers after falling clock
module smf_mem_model (
	input  wire logic i_sclk,
	input  wire logic i_cs_n,
	input  wire logic i_mosi,
	output logic      o_miso
);
	logic [7:0] sh, got [$];
	int         bits, prog_count;
	// Answer byte n is 40h plus n, MSB first
	function automatic logic bitv(int n);
		logic [7:0] v = 8'h40 + 8'(n / 8);
		return v[7 - n % 8];
	endfunction
	initial o_miso = 1'b1;
	// Capture while selected, MSB first
	always @(posedge i_sclk) if (!i_cs_n) begin
		sh = {sh[6:0], i_mosi};
		bits++;
		if (bits % 8 == 0) got.push_back(sh);
	end
	// Frame start presents the first answer bit
	always @(negedge i_cs_n) begin
		bits = 0;
		o_miso = bitv(0);
	end
	always @(negedge i_sclk) if (!i_cs_n) o_miso = bitv(bits);
	// Release shows the inverse level; a written page programs here
	always @(posedge i_cs_n) begin
		o_miso = ~o_miso;
		if (bits > 0) prog_count++;
	end
endmodule // smf_mem_model

/* test/tb.sv */
`timescale 1ns/1ps
module tb;
	import smf_pkg::*;
	localparam int HC = 8; // 80 ns serial clock
	logic i_clock, i_arst_n, i_serial_enable_bit, i_start_register_select, i_tx_first_wr;
	logic i_tx_second_wr, i_done_clear, o_done_flag, o_busy, i_chip_select_field_func;
	logic i_cs_dir_wr, i_cs_dir_val, i_cs_gp_out, o_cs_dir, o_fault_pin_zero, o_fault_pin_zero_oe;
	logic o_fault_pin_one, o_fault_pin_one_oe, o_serial_out_pin, o_serial_out_pin_oe;
	logic i_serial_in_pin, o_cs_gp_in;
	logic [3:0] i_transmit_count, i_fault_mux_sel, i_tdata_mux_sel;
	logic [4:0] i_receive_count, i_frame_message_count;
	logic [31:0] i_tx_wdata, o_rx_word, e;
	logic [1:0] i_rx_word_sel;
	int fails, cmp_count, cyc, b;
	// Released lines: select pulled high, clock low, data high
	wire cs_w = o_fault_pin_zero_oe ? o_fault_pin_zero : 1'b1;
	wire sck_w = o_fault_pin_one_oe ? o_fault_pin_one : 1'b0;
	wire mo_w = o_serial_out_pin_oe ? o_serial_out_pin : 1'b1;
	smf_engine #(.HALF_CYC(HC)) dut (
		.i_clock(i_clock), .i_arst_n(i_arst_n), .i_serial_enable_bit(i_serial_enable_bit),
		.i_transmit_count(i_transmit_count), .i_receive_count(i_receive_count),
		.i_frame_message_count(i_frame_message_count),
		.i_start_register_select(i_start_register_select), .i_tx_first_wr(i_tx_first_wr),
		.i_tx_second_wr(i_tx_second_wr), .i_tx_wdata(i_tx_wdata), .i_done_clear(i_done_clear),
		.o_done_flag(o_done_flag), .o_busy(o_busy), .i_rx_word_sel(i_rx_word_sel),
		.o_rx_word(o_rx_word), .i_chip_select_field_func(i_chip_select_field_func),
		.i_cs_dir_wr(i_cs_dir_wr), .i_cs_dir_val(i_cs_dir_val), .i_cs_gp_out(i_cs_gp_out),
		.o_cs_dir(o_cs_dir), .i_fault_mux_sel(i_fault_mux_sel),
		.i_tdata_mux_sel(i_tdata_mux_sel),
		.o_fault_pin_zero(o_fault_pin_zero), .o_fault_pin_zero_oe(o_fault_pin_zero_oe),
		.o_fault_pin_one(o_fault_pin_one), .o_fault_pin_one_oe(o_fault_pin_one_oe),
		.o_serial_out_pin(o_serial_out_pin), .o_serial_out_pin_oe(o_serial_out_pin_oe),
		.i_serial_in_pin(i_serial_in_pin), .o_cs_gp_in(o_cs_gp_in));
	smf_mem_model mem (.i_sclk(sck_w), .i_cs_n(cs_w), .i_mosi(mo_w), .o_miso(i_serial_in_pin));
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("Compared %0d, mismatched %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(negedge i_clock);
	endtask
	// One transmit word write
	task automatic wr(logic second, logic [31:0] d);
		tick(1);
		i_tx_wdata = d;
		i_tx_first_wr = !second;
		i_tx_second_wr = second;
		tick(1);
		i_tx_first_wr = 0;
		i_tx_second_wr = 0;
	endtask
	// Wait for message end, then clear the flag
	task automatic fin();
		int n = 0;
		while (o_done_flag !== 1'b1 && n < 9000) begin
			tick(1);
			n++;
		end
		tick(1);
		check("done held", 1, o_done_flag);
		i_done_clear = 1;
		tick(1);
		i_done_clear = 0;
		check("done clear", 0, o_done_flag);
	endtask
	task automatic cnt(logic [3:0] t, logic [4:0] r);
		i_transmit_count = t;
		i_receive_count = r;
	endtask
	task automatic rdw(logic [1:0] w);
		i_rx_word_sel = w;
		tick(3);
	endtask
	// Routing, software select, direction reset
	task automatic t_pins();
		check("dir", CS_DIR_RESET, o_cs_dir);
		// Enables follow the selects one edge after reset release
		tick(2);
		check("oe", 3'h7, {o_fault_pin_zero_oe, o_fault_pin_one_oe, o_serial_out_pin_oe});
		i_fault_mux_sel = 4'h0;
		i_tdata_mux_sel = 4'h1;
		tick(2);
		check("oe off", 3'h0, {o_fault_pin_zero_oe, o_fault_pin_one_oe, o_serial_out_pin_oe});
		i_fault_mux_sel = FAULT_SEL_SERIAL;
		i_tdata_mux_sel = TDATA_SEL_SERIAL;
		i_chip_select_field_func = 1;
		for (int v = 0; v < 2; v++) begin
			i_cs_gp_out = v[0];
			tick(3);
			check("gp pin", {v[0], v[0]}, {o_fault_pin_zero, o_cs_gp_in});
		end
		// Direction cleared while software owns the pin stops driving it
		i_cs_dir_val = 0;
		i_cs_dir_wr = 1;
		tick(1);
		i_cs_dir_wr = 0;
		tick(1);
		check("dir wr", 2'h0, {o_cs_dir, o_fault_pin_zero_oe});
		i_cs_dir_val = 1;
		i_cs_dir_wr = 1;
		tick(1);
		i_cs_dir_wr = 0;
		i_chip_select_field_func = 0;
		tick(2);
	endtask
	// Start ignored while off
	task automatic t_off();
		cnt(4'h2, 5'h0);
		wr(0, 32'h0);
		tick(4);
		check("off", 2'h0, {o_busy, o_done_flag});
		i_serial_enable_bit = 1;
	endtask
	// Longest counts: both buffers wrap
	task automatic t_long();
		b = mem.got.size();
		cnt(4'hf, 5'h1f);
		wr(1, 32'h8877_6655);
		check("stored", 0, o_busy);
		wr(0, 32'h4433_2211);
		check("start", 2'h2, {o_busy, cs_w});
		fin();
		check("cs end", 1, cs_w);
		for (int k = 0; k < 15; k++) check("tx", 8'h11 * (k % 8 + 1), mem.got[b + k]);
		for (int w = 0; w < 4; w++) begin
			for (int i = 0; i < 4; i++) e[8*i +: 8] = 8'h4f + 8'(4*w + i + (4*w + i < 15 ? 16 : 0));
			rdw(w[1:0]);
			check("rx", e, o_rx_word);
		end
	endtask
	// Three messages under one select
	task automatic t_frame();
		b = mem.got.size();
		i_frame_message_count = 5'h3;
		cnt(4'h2, 5'h0);
		wr(0, 32'h0000_a55a);
		fin();
		check("cs held", 0, cs_w);
		cnt(4'h0, 5'h4);
		wr(0, 32'h0);
		check("rx only", 1, o_busy);
		fin();
		rdw(0);
		check("rx", 32'h4544_4342, o_rx_word);
		i_start_register_select = 1;
		cnt(4'h8, 5'h0);
		wr(0, 32'h0403_0201);
		wr(1, 32'h0807_0605);
		fin();
		check("cs free", 1, cs_w);
		check("sent", b + 14, mem.got.size());
		// One page program per frame: long single message, then this frame
		check("programmed", 2, mem.prog_count);
		for (int k = 0; k < 8; k++) check("tx", k + 1, mem.got[b + 6 + k]);
		i_start_register_select = 0;
	endtask
	initial begin
		i_clock = 0;
		forever #2.5 i_clock = ~i_clock;
	end
	// Hang limit
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			stop_test();
		end
	end
	initial begin
		{i_serial_enable_bit, i_start_register_select, i_tx_first_wr, i_tx_second_wr} = '0;
		{i_done_clear, i_chip_select_field_func, i_cs_dir_wr, i_cs_dir_val, i_cs_gp_out} = '0;
		cnt(4'h1, 5'h1);
		i_frame_message_count = 5'h1;
		i_tx_wdata = 32'h0;
		i_rx_word_sel = 2'h0;
		i_fault_mux_sel = FAULT_SEL_SERIAL;
		i_tdata_mux_sel = TDATA_SEL_SERIAL;
		i_arst_n = 0;
		tick(16);
		i_arst_n = 1;
		t_pins();
		t_off();
		t_long();
		t_frame();
		stop_test();
	end
endmodule // tb
